/* hdl/ard_params.svh */
`ifndef ARD_PARAMS_SVH
`define ARD_PARAMS_SVH

// Register indices on the plain register port
`define ARD_ADDR_W 4
`define ARD_OFF_RX_DATA 4'h0
`define ARD_OFF_RX_CTRL 4'h1
`define ARD_OFF_BAUD 4'h2
`define ARD_OFF_TX_CTRL 4'h3
`define ARD_OFF_TX_DATA 4'h4
`define ARD_OFF_IRQ_EN 4'h5

// receive_status_control fields
`define ARD_RC_PORT_EN 7
`define ARD_RC_RX9 6
`define ARD_RC_SINGLE 5
`define ARD_RC_CONT 4
`define ARD_RC_ADDR 3
`define ARD_RC_FRAMING_ERROR_FLAG 2
`define ARD_RC_OVERRUN_ERROR_FLAG 1
`define ARD_RC_RECEIVED_NINTH_BIT 0

// transmit_status_control fields
`define ARD_TC_CLKSRC 7
`define ARD_TC_TX9 6
`define ARD_TC_TRANSMIT_ENABLE_BIT 5
`define ARD_TC_SYNC 4
`define ARD_TC_HIGH_SPEED_BAUD_SELECT 2
`define ARD_TC_SHIFT_REGISTER_EMPTY_FLAG 1
`define ARD_TC_TRANSMIT_NINTH_BIT 0

`define ARD_RST_BYTE 8'h00
`define ARD_RST_TX_CTRL 8'h02

// Oversampling: sixteen ticks per bit, start verified after eight
`define ARD_OVS_LAST 4'hf
`define ARD_HALF_LAST 4'h7
`define ARD_BITS8_LAST 4'h7
`define ARD_BITS9_LAST 4'h8
`define ARD_FRAME8_LAST 4'h9
`define ARD_FRAME9_LAST 4'ha

`endif

/* hdl/ard_pkg.sv */
package ard_pkg;
  typedef enum logic [1:0] {
    ARD_RX_IDLE = 2'b00,
    ARD_RX_START = 2'b01,
    ARD_RX_DATA = 2'b10,
    ARD_RX_STOP = 2'b11
  } ard_rx_state_e;
  typedef enum logic [0:0] {
    ARD_TX_IDLE = 1'b0,
    ARD_TX_SEND = 1'b1
  } ard_tx_state_e;
endpackage : ard_pkg

/* hdl/ard_char_if.sv */
interface ard_char_if;
  logic valid;
  logic [8:0] data;
  logic frameErr;
  modport source (output valid, output data, output frameErr);
  modport sink (input valid, input data, input frameErr);
endinterface : ard_char_if

/* hdl/ard_bit_rx.sv */
`include "ard_params.svh"

module ard_bit_rx
  import ard_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic enable,
  input wire logic tick,
  input wire logic nineBit,
  input wire logic rxIn,
  ard_char_if.source chr
);
  ard_rx_state_e state;
  logic rxPrev;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [8:0] shift;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ARD_RX_IDLE;
      rxPrev <= 1'b1;
      cnt <= 4'h0;
      idx <= 4'h0;
      shift <= 9'h000;
      chr.valid <= 1'b0;
      chr.data <= 9'h000;
      chr.frameErr <= 1'b0;
    end else if (ce) begin
      chr.valid <= 1'b0;
      if (tick) begin
        rxPrev <= rxIn;
      end
      if (!enable) begin
        state <= ARD_RX_IDLE;
      end else if (tick) begin
        case (state)
          ARD_RX_IDLE: begin
            if (rxPrev && !rxIn) begin
              state <= ARD_RX_START;
              cnt <= 4'h0;
            end
          end
          ARD_RX_START: begin
            if (cnt == `ARD_HALF_LAST) begin
              // A glitch shorter than half a bit is dropped silently
              state <= rxIn ? ARD_RX_IDLE : ARD_RX_DATA;
              cnt <= 4'h0;
              idx <= 4'h0;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ARD_RX_DATA: begin
            if (cnt == `ARD_OVS_LAST) begin
              cnt <= 4'h0;
              shift <= {rxIn, shift[8:1]};
              idx <= idx + 4'h1;
              if (idx == (nineBit ? `ARD_BITS9_LAST : `ARD_BITS8_LAST)) begin
                state <= ARD_RX_STOP;
              end
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          ARD_RX_STOP: begin
            if (cnt == `ARD_OVS_LAST) begin
              chr.valid <= 1'b1;
              chr.data <= nineBit ? shift : {1'b0, shift[8:1]};
              chr.frameErr <= !rxIn;
              state <= ARD_RX_IDLE;
            end else begin
              cnt <= cnt + 4'h1;
            end
          end
          default: state <= ARD_RX_IDLE;
        endcase
      end
    end
  end
endmodule : ard_bit_rx

/* hdl/ard_fifo.sv */
module ard_fifo #(
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic pop,
  ard_char_if.sink chr,
  output logic [8:0] topData,
  output logic topFerr,
  output logic full,
  output logic empty
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [9:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : nextPtr

  assign full = (count == CW'(DEPTH));
  assign empty = (count == '0);
  assign topData = mem[rdPtr][8:0];
  assign topFerr = mem[rdPtr][9];

  always_ff @(posedge sys_clk) begin
    if (ce && push && !full) begin
      mem[wrPtr] <= {chr.frameErr, chr.data};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (ce) begin
      if (flush) begin
        wrPtr <= '0;
        rdPtr <= '0;
        count <= '0;
      end else begin
        if (push && !full) begin
          wrPtr <= nextPtr(wrPtr);
        end
        if (pop && !empty) begin
          rdPtr <= nextPtr(rdPtr);
        end
        count <= count + CW'(push && !full) - CW'(pop && !empty);
      end
    end
  end
endmodule : ard_fifo

/* hdl/ard_top.sv */
// Decided for this implementation: the strobed register port and the placing of the registers.
`include "ard_params.svh"

// Behaviour
// - Port enable bit turns the port on; clear means inactive.
// - Ninth-bit receive select chooses nine or eight data bits.
// - Address-detect enable puts receiver into address-detection mode.
// - Characters accepted only while continuous receive enable is set.
// - In address mode, ninth-bit-one character stored sets receive flag.
// - Interrupt request raised only with receive interrupt enable set.
// - In address mode every stored ninth bit reads back one.
// - Reading receive data returns low eight bits of oldest character.
// - Clearing continuous receive enable clears overrun flag.
// - Address detect cleared lets every character in and flag.
// - Third complete character before a read sets overrun flag.
// - Ninth-bit transmit select chooses nine or eight transmitted bits.
// - Clearing transmit enable disables the transmitter.
// - Mode select one means synchronous, zero asynchronous; here one only holds receiver and transmitter idle.
// - Receive FIFO holds exactly two characters.
// - In address mode, ninth-bit-zero characters are discarded.
// - Status ninth bit belongs to the top unread character.
// - During overrun nothing new is stored; stored characters stay readable.
module ard_top
  import ard_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [`ARD_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic rxPin,
  output logic txPin,
  output logic rxFlag,
  output logic rxIrq
);
  // receive_status_control writable bits and the overrun flag
  logic portEn;
  logic rx9;
  logic singleRx;
  logic contRx;
  logic addrDet;
  logic overrun;
  // transmit_status_control writable bits
  logic clkSrc;
  logic tx9;
  logic transmit_enable_bit;
  logic syncMode;
  logic high_speed_baud_select;
  logic transmit_ninth_bit;
  logic [7:0] baudDiv;
  logic rxIe;

  logic [9:0] baudCnt;
  logic tick;
  logic rxEnable;
  logic accept;
  logic overrunNow;
  logic push;
  logic pop;
  logic fifoFull;
  logic fifoEmpty;
  logic [8:0] topData;
  logic topFerr;
  logic wrRxCtrl;
  logic [7:0] rxCtrlRead;
  logic [7:0] txCtrlRead;
  logic [7:0] next_rdData;

  ard_tx_state_e txState;
  logic [10:0] txShift;
  logic [3:0] txTicks;
  logic [3:0] txBits;
  logic txBusy;

  ard_char_if chr ();

  function automatic logic regHit(input logic [`ARD_ADDR_W-1:0] a,
                                  input logic [`ARD_ADDR_W-1:0] off);
    regHit = (a == off);
  endfunction : regHit

  // Port runs only when on and in asynchronous mode
  assign rxEnable = portEn && contRx && !syncMode && !overrun;
  assign wrRxCtrl = wrStb && regHit(addr, `ARD_OFF_RX_CTRL);
  assign pop = rdStb && regHit(addr, `ARD_OFF_RX_DATA) && !fifoEmpty;
  // Only ninth-bit-one characters pass in address mode
  assign accept = chr.valid && (!addrDet || chr.data[8]);
  // A read in the same cycle means no overrun, but the full FIFO still refuses the push, so the character is lost
  assign overrunNow = accept && fifoFull && !pop;
  assign push = accept && !overrunNow;
  assign txBusy = (txState == ARD_TX_SEND);

  ard_bit_rx u_bit_rx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .enable(rxEnable),
    .tick(tick),
    .nineBit(rx9),
    .rxIn(rxPin),
    .chr(chr.source)
  );

  ard_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .flush(!portEn),
    .push(push),
    .pop(pop),
    .chr(chr.sink),
    .topData(topData),
    .topFerr(topFerr),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  // Sixteen ticks per bit; low speed divides a further four times
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      baudCnt <= 10'h000;
      tick <= 1'b0;
    end else if (ce) begin
      if (!portEn) begin
        baudCnt <= 10'h000;
        tick <= 1'b0;
      end else if (baudCnt == (high_speed_baud_select ? {2'b00, baudDiv} : {baudDiv, 2'b11})) begin
        baudCnt <= 10'h000;
        tick <= 1'b1;
      end else begin
        baudCnt <= baudCnt + 10'h001;
        tick <= 1'b0;
      end
    end
  end

  // receive_status_control control bits
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      portEn <= 1'b0;
      rx9 <= 1'b0;
      singleRx <= 1'b0;
      contRx <= 1'b0;
      addrDet <= 1'b0;
    end else if (ce && wrRxCtrl) begin
      portEn <= wrData[`ARD_RC_PORT_EN];
      rx9 <= wrData[`ARD_RC_RX9];
      singleRx <= wrData[`ARD_RC_SINGLE];
      contRx <= wrData[`ARD_RC_CONT];
      addrDet <= wrData[`ARD_RC_ADDR];
    end
  end

  // Overrun: a new overrun wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      overrun <= 1'b0;
    end else if (ce) begin
      if (overrunNow) begin
        overrun <= 1'b1;
      end else if (!portEn || (wrRxCtrl && !wrData[`ARD_RC_CONT])) begin
        overrun <= 1'b0;
      end
    end
  end

  // transmit_status_control, baud divisor and interrupt enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkSrc <= 1'b0;
      tx9 <= 1'b0;
      transmit_enable_bit <= 1'b0;
      syncMode <= 1'b0;
      high_speed_baud_select <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      baudDiv <= `ARD_RST_BYTE;
      rxIe <= 1'b0;
    end else if (ce && wrStb) begin
      if (regHit(addr, `ARD_OFF_TX_CTRL)) begin
        clkSrc <= wrData[`ARD_TC_CLKSRC];
        tx9 <= wrData[`ARD_TC_TX9];
        transmit_enable_bit <= wrData[`ARD_TC_TRANSMIT_ENABLE_BIT];
        syncMode <= wrData[`ARD_TC_SYNC];
        high_speed_baud_select <= wrData[`ARD_TC_HIGH_SPEED_BAUD_SELECT];
        transmit_ninth_bit <= wrData[`ARD_TC_TRANSMIT_NINTH_BIT];
      end
      if (regHit(addr, `ARD_OFF_BAUD)) begin
        baudDiv <= wrData;
      end
      if (regHit(addr, `ARD_OFF_IRQ_EN)) begin
        rxIe <= wrData[0];
      end
    end
  end

  // Flag follows FIFO occupancy; software cannot touch it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxFlag <= 1'b0;
      rxIrq <= 1'b0;
    end else if (ce) begin
      rxFlag <= portEn && !fifoEmpty;
      rxIrq <= portEn && !fifoEmpty && rxIe;
    end
  end

  // Transmitter: no holding register, a write while busy is dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txState <= ARD_TX_IDLE;
      txShift <= 11'h7ff;
      txTicks <= 4'h0;
      txBits <= 4'h0;
      txPin <= 1'b1;
    end else if (ce) begin
      if (!transmit_enable_bit || !portEn || syncMode) begin
        txState <= ARD_TX_IDLE;
        txPin <= 1'b1;
      end else begin
        case (txState)
          ARD_TX_IDLE: begin
            txPin <= 1'b1;
            if (wrStb && regHit(addr, `ARD_OFF_TX_DATA)) begin
              // Stop, optional ninth bit, data, start
              txShift <= {1'b1, tx9 ? transmit_ninth_bit : 1'b1, wrData, 1'b0};
              txTicks <= 4'h0;
              txBits <= 4'h0;
              txState <= ARD_TX_SEND;
            end
          end
          ARD_TX_SEND: begin
            txPin <= txShift[0];
            if (tick) begin
              if (txTicks == `ARD_OVS_LAST) begin
                txTicks <= 4'h0;
                txShift <= {1'b1, txShift[10:1]};
                txBits <= txBits + 4'h1;
                if (txBits == (tx9 ? `ARD_FRAME9_LAST : `ARD_FRAME8_LAST)) begin
                  txState <= ARD_TX_IDLE;
                end
              end else begin
                txTicks <= txTicks + 4'h1;
              end
            end
          end
          default: txState <= ARD_TX_IDLE;
        endcase
      end
    end
  end

  // Framing error and ninth bit describe the top unread character, zero when empty
  always_comb begin
    rxCtrlRead = `ARD_RST_BYTE;
    rxCtrlRead[`ARD_RC_PORT_EN] = portEn;
    rxCtrlRead[`ARD_RC_RX9] = rx9;
    rxCtrlRead[`ARD_RC_SINGLE] = singleRx;
    rxCtrlRead[`ARD_RC_CONT] = contRx;
    rxCtrlRead[`ARD_RC_ADDR] = addrDet;
    rxCtrlRead[`ARD_RC_FRAMING_ERROR_FLAG] = !fifoEmpty && topFerr;
    rxCtrlRead[`ARD_RC_OVERRUN_ERROR_FLAG] = overrun;
    rxCtrlRead[`ARD_RC_RECEIVED_NINTH_BIT] = !fifoEmpty && topData[8];
  end

  always_comb begin
    txCtrlRead = `ARD_RST_BYTE;
    txCtrlRead[`ARD_TC_CLKSRC] = clkSrc;
    txCtrlRead[`ARD_TC_TX9] = tx9;
    txCtrlRead[`ARD_TC_TRANSMIT_ENABLE_BIT] = transmit_enable_bit;
    txCtrlRead[`ARD_TC_SYNC] = syncMode;
    txCtrlRead[`ARD_TC_HIGH_SPEED_BAUD_SELECT] = high_speed_baud_select;
    txCtrlRead[`ARD_TC_SHIFT_REGISTER_EMPTY_FLAG] = !txBusy;
    txCtrlRead[`ARD_TC_TRANSMIT_NINTH_BIT] = transmit_ninth_bit;
  end

  always_comb begin
    next_rdData = `ARD_RST_BYTE;
    if (rdStb) begin
      case (addr)
        `ARD_OFF_RX_DATA: next_rdData = fifoEmpty ? `ARD_RST_BYTE : topData[7:0];
        `ARD_OFF_RX_CTRL: next_rdData = rxCtrlRead;
        `ARD_OFF_BAUD: next_rdData = baudDiv;
        `ARD_OFF_TX_CTRL: next_rdData = txCtrlRead;
        `ARD_OFF_IRQ_EN: next_rdData = {7'h00, rxIe};
        default: next_rdData = `ARD_RST_BYTE;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= `ARD_RST_BYTE;
    end else if (ce) begin
      rdData <= next_rdData;
    end
  end
endmodule : ard_top

/* bench/ard_top_chk.sv */
`include "ard_params.svh"

module ard_top_chk #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [`ARD_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdData,
  input wire logic rxPin,
  input wire logic txPin,
  input wire logic rxFlag,
  input wire logic rxIrq
);
  // Ages saturate so a long quiet spell never wraps to a small value
  logic [9:0] lowAge;
  logic [9:0] txAge;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) lowAge <= 10'h3ff;
    else if (!rxPin) lowAge <= 10'h000;
    else if (lowAge != 10'h3ff) lowAge <= lowAge + 10'h001;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) txAge <= 10'h3ff;
    else if (wrStb && addr == `ARD_OFF_TX_DATA) txAge <= 10'h000;
    else if (txAge != 10'h3ff) txAge <= txAge + 10'h001;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  irq_needs_flag_a: assert property (rxIrq |-> rxFlag || $past(rxFlag))
    else $error("interrupt without receive flag");
  irq_drop_a: assert property ($fell(rxFlag) |-> ##[0:1] !rxIrq)
    else $error("interrupt outlives receive flag");
  read_slot_a: assert property (!$past(rdStb) |-> rdData == 8'h00)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property ($past(rdStb) && ($past(addr) == `ARD_OFF_TX_DATA ||
    $past(addr) > `ARD_OFF_IRQ_EN) |-> rdData == 8'h00)
    else $error("unreadable index returned data");
  flag_hold_a: assert property ($fell(rxFlag) |->
    $past(rdStb && addr == `ARD_OFF_RX_DATA, 2) || $past(rdStb && addr == `ARD_OFF_RX_DATA) ||
    $past(wrStb && addr == `ARD_OFF_RX_CTRL, 2) || $past(wrStb && addr == `ARD_OFF_RX_CTRL))
    else $error("receive flag dropped without read");
  flag_cause_a: assert property ($rose(rxFlag) |-> lowAge < 10'd200)
    else $error("receive flag without a frame");
  tx_cause_a: assert property ($fell(txPin) |-> txAge < 10'd200)
    else $error("transmit line moved without data");
  tx_bit_len_a: assert property ($fell(txPin) |-> (!txPin) [*8])
    else $error("transmit low bit too short");

  cover property ($rose(rxIrq));
  cover property ($fell(rxFlag));
  cover property ($fell(txPin));
endmodule : ard_top_chk

bind ard_top ard_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .rxPin(rxPin), .txPin(txPin), .rxFlag(rxFlag), .rxIrq(rxIrq));

/* bench/ard_far_tx.sv */
module ard_far_tx #(
  parameter int BIT_CLKS = 16
) (
  input wire logic sys_clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line starts driven high and is driven high for each stop bit and left there, so it idles high between frames
  initial line = 1'b1;

  task automatic send(input logic [8:0] d, input logic nine);
    @(posedge sys_clk);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge sys_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    line <= 1'b1;
    repeat (BIT_CLKS) @(posedge sys_clk);
  endtask : send
endmodule : ard_far_tx

/* bench/test_async_rx_address_detect.sv */
`include "ard_params.svh"

module test_async_rx_address_detect;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`ARD_ADDR_W-1:0] addr = '0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic rxPin;
  logic txPin;
  logic rxFlag;
  logic rxIrq;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] v;
  logic [8:0] c [4];
  logic [10:0] f;
  logic bad;
  logic [3:0] rA [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'hf};
  logic [7:0] rE [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

  always #4 sys_clk = ~sys_clk;

  ard_top #(.FIFO_DEPTH(2)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .rxPin(rxPin),
    .txPin(txPin), .rxFlag(rxFlag), .rxIrq(rxIrq));
  ard_far_tx #(.BIT_CLKS(16)) i_far (.sys_clk(sys_clk), .line(rxPin));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge sys_clk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge sys_clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask : rd

  // Flag is up two clocks after the stop sample, well inside four
  task automatic rx(input logic [8:0] d, input logic nine);
    i_far.send(d, nine);
    settle(4);
  endtask : rx

  initial begin
    void'($urandom(32'h500d3318));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(rA[i], v);
      check(9'(v), 9'(rE[i]));
    end
    done("reset");
    wr(`ARD_OFF_BAUD, 8'h00);
    wr(`ARD_OFF_TX_CTRL, 8'h04);
    wr(`ARD_OFF_RX_CTRL, 8'h80);
    rx(9'($urandom), 1'b0);
    check(9'(rxFlag), 9'h0);
    wr(`ARD_OFF_RX_CTRL, 8'h50);
    rx(9'($urandom), 1'b1);
    check(9'(rxFlag), 9'h0);
    wr(`ARD_OFF_RX_CTRL, 8'h90);
    c[0] = 9'($urandom);
    rx(c[0], 1'b0);
    check(9'(rxFlag), 9'h1);
    check(9'(rxIrq), 9'h0);
    rd(`ARD_OFF_RX_DATA, v);
    check(9'(v), 9'(c[0][7:0]));
    settle(2);
    check(9'(rxFlag), 9'h0);
    done("eight-bit");
    wr(`ARD_OFF_IRQ_EN, 8'h01);
    wr(`ARD_OFF_RX_CTRL, 8'hd8);
    for (int k = 0; k < 4; k++) begin
      c[0] = 9'($urandom);
      c[0][8] = k[0];
      rx(c[0], 1'b1);
      check(9'(rxFlag), 9'(c[0][8]));
      check(9'(rxIrq), 9'(c[0][8]));
      if (c[0][8]) begin
        rd(`ARD_OFF_RX_CTRL, v);
        check(9'(v[0]), 9'h1);
        rd(`ARD_OFF_RX_DATA, v);
        check(9'(v), 9'(c[0][7:0]));
        settle(2);
        check(9'(rxFlag), 9'h0);
      end
    end
    done("address");
    wr(`ARD_OFF_RX_CTRL, 8'hd0);
    for (int k = 0; k < 3; k++) begin
      c[k] = 9'($urandom);
      c[k][8] = k[0];
      rx(c[k], 1'b1);
    end
    check(9'(rxFlag), 9'h1);
    rd(`ARD_OFF_RX_CTRL, v);
    check(9'(v[1]), 9'h1);
    check(9'(v[0]), 9'(c[0][8]));
    rd(`ARD_OFF_RX_DATA, v);
    check(9'(v), 9'(c[0][7:0]));
    rd(`ARD_OFF_RX_CTRL, v);
    check(9'(v[0]), 9'(c[1][8]));
    rd(`ARD_OFF_RX_DATA, v);
    check(9'(v), 9'(c[1][7:0]));
    settle(2);
    check(9'(rxFlag), 9'h0);
    rx(9'($urandom), 1'b1);
    check(9'(rxFlag), 9'h0);
    wr(`ARD_OFF_RX_CTRL, 8'hc0);
    rd(`ARD_OFF_RX_CTRL, v);
    check(9'(v[1]), 9'h0);
    done("overrun");
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      wr(`ARD_OFF_TX_CTRL, 8'h24 | 8'(k * 65));
      wr(`ARD_OFF_TX_DATA, v);
      f = {2'b11, v, 1'b0};
      // Look a step after each edge so the launching edge never races the read
      for (int n = 0; n < 40 && txPin !== 1'b0; n++) settle(1);
      if (txPin !== 1'b0) begin
        err_total++;
        summarize();
      end
      for (int j = 0; j < 11; j++) begin
        settle(j == 0 ? 8 : 16);
        check(9'(txPin), 9'(f[j]));
      end
    end
    done("transmit");
    // Disabled, then synchronous: both must keep the line idle
    for (int k = 0; k < 2; k++) begin
      wr(`ARD_OFF_TX_CTRL, (k != 0) ? 8'h34 : 8'h04);
      wr(`ARD_OFF_TX_DATA, 8'h00);
      bad = 1'b0;
      repeat (40) begin
        @(posedge sys_clk);
        if (txPin !== 1'b1) bad = 1'b1;
      end
      check(9'(bad), 9'h0);
    end
    done("transmit off");
    summarize();
  end
endmodule : test_async_rx_address_detect
